// File: shared/acq_timing_pkg.sv
// Constants, register map and state type of the acquisition timing engine
package acq_timing_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 16;

    localparam logic [ADDR_W-1:0] REG_CTRL   = 5'h00;
    localparam logic [ADDR_W-1:0] REG_CMD    = 5'h04;
    localparam logic [ADDR_W-1:0] REG_DIV    = 5'h08;
    localparam logic [ADDR_W-1:0] REG_DELAY  = 5'h0C;
    localparam logic [ADDR_W-1:0] REG_COUNT  = 5'h10;
    localparam logic [ADDR_W-1:0] REG_PRE    = 5'h14;
    localparam logic [ADDR_W-1:0] REG_STATUS = 5'h18;
    localparam logic [ADDR_W-1:0] REG_TAKEN  = 5'h1C;

    localparam int C_CONT      = 0;
    localparam int C_REF       = 1;
    localparam int C_RETRIG    = 2;
    localparam int C_HWSTART   = 3;
    localparam int C_START_FALL = 4;
    localparam int C_REF_FALL  = 5;
    localparam int C_HOLD_EN   = 6;
    localparam int C_HOLD_LOW  = 7;
    localparam int C_EXT_SCLK  = 8;
    localparam int C_TB_LSB    = 9;
    localparam int C_TB_FALL   = 11;
    localparam int C_SAMP_FALL = 12;

    localparam int CMD_START   = 0;
    localparam int CMD_STOP    = 1;
    localparam int CMD_CLR_OVF = 2;

    localparam int S_RUN     = 0;
    localparam int S_ARMED   = 1;
    localparam int S_REFSEEN = 2;
    localparam int S_OVF     = 3;
    localparam int S_WAIT    = 4;

    localparam logic [DATA_W-1:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [CNT_W-1:0]  DIV_RST   = 16'h0002;
    localparam logic [CNT_W-1:0]  DELAY_RST = 16'h0002;
    localparam logic [CNT_W-1:0]  COUNT_RST = 16'h0010;
    localparam logic [CNT_W-1:0]  PRE_RST   = 16'h0000;

    localparam logic [1:0] TB_100M = 2'h0;
    localparam logic [1:0] TB_20M  = 2'h1;
    localparam logic [1:0] TB_EXT  = 2'h2;

    localparam int IN_START = 0;
    localparam int IN_REF   = 1;
    localparam int IN_HOLD  = 2;
    localparam int IN_TB    = 3;
    localparam int IN_SCLK  = 4;
    localparam int IN_N     = 5;

    localparam longint CLK_HZ   = 100_000_000;
    localparam longint TB20_HZ  = 20_000_000;
    localparam int     TB20_DIV = int'(CLK_HZ / TB20_HZ);

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARM   = 2'b01,
        ST_DELAY = 2'b10,
        ST_RUN   = 2'b11
    } acq_state_t;
endpackage

// File: hw/acq_sync.sv
// Two-stage input synchroniser with level and edge outputs
`timescale 1ns/1ns
module acq_sync #(
    parameter int N = 5
) (
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic [N-1:0] din,
    output logic      [N-1:0] lvl,
    output logic      [N-1:0] rise,
    output logic      [N-1:0] fall
);
    logic [1:0] fill_r;
    logic       live;

    // No edges until the edge stage holds a real pin sample, so reset release shows none
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fill_r <= 2'h0;
        end else if (!live) begin
            fill_r <= fill_r + 2'h1;
        end
    end
    assign live = (fill_r == 2'h3);

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_bit
            logic meta_r;
            logic sync_r;
            logic prev_r;
            // Only the second stage reads the first one
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                    prev_r <= 1'b0;
                end else begin
                    meta_r <= din[i];
                    sync_r <= meta_r;
                    prev_r <= sync_r;
                end
            end
            assign lvl[i]  = sync_r;
            assign rise[i] = sync_r & ~prev_r & live;
            assign fall[i] = ~sync_r & prev_r & live;
        end
    endgenerate
endmodule // acq_sync

// File: hw/acq_timebase.sv
// Timebase tick generator: 100 MHz, 20 MHz or external edge
`timescale 1ns/1ns
module acq_timebase (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic [1:0] tb_sel,
    input  wire logic       tb_fall,
    input  wire logic       ext_rise,
    input  wire logic       ext_fall,
    output logic            tb_tick
);
    import acq_timing_pkg::*;

    logic [7:0] div20_r;
    logic       tick_nxt;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            div20_r <= 8'h00;
        end else if (div20_r == 8'(TB20_DIV - 1)) begin
            div20_r <= 8'h00;
        end else begin
            div20_r <= div20_r + 8'h01;
        end
    end

    always_comb begin
        case (tb_sel)
            TB_100M: tick_nxt = 1'b1;
            TB_20M:  tick_nxt = (div20_r == 8'h00);
            TB_EXT:  tick_nxt = tb_fall ? ext_fall : ext_rise;
            default: tick_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tb_tick <= 1'b0;
        end else begin
            tb_tick <= tick_nxt;
        end
    end
endmodule // acq_timebase

// File: hw/acq_timing_engine.sv
// Hardware-timed acquisition timing and trigger engine
// Operation
// - Sample edges ignored outside an acquisition
// - Internal sample clock unless external selected
// - Start trigger runs; software or hardware stops
// - Programmable start delay, reset two ticks
// - Timebase defaults to onboard 100 MHz
// - Divider forms internal sample clock
// - Timebase edge selectable except internal references
// - Software start when no hardware trigger
// - Finite stops on count/reference; continuous on software
// - Retrigger repeats burst per start pulse
// - Start ignored during burst, then re-armed
// - One reference trigger per acquisition
// - Start trigger edge selectable
// - Start trigger output is active-high pulse
// - Posttrigger count is buffer minus pretrigger
// - Reference ignored until pretrigger samples taken
// - Full buffer discards oldest per new sample
// - After reference, store posttrigger samples, end
// - Reference trigger edge selectable
// - Pause halts sample clock, resumes when inactive
// - Pause is level-sensitive, polarity programmable
// - Port captured on selected sample clock edge
// - Sample while FIFO full flags overflow
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ns
module acq_timing_engine #(
    parameter int PORT_W = 32
) (
    input  wire logic                              clock,
    input  wire logic                              nrst,
    input  wire logic [acq_timing_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [acq_timing_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    output logic      [acq_timing_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic [PORT_W-1:0]                 port_in,
    input  wire logic                              acq_start_trig,
    input  wire logic                              acq_stop_ref_trig,
    input  wire logic                              acq_hold_trig,
    input  wire logic                              acq_clock_timebase,
    input  wire logic                              acq_sample_clock,
    input  wire logic                              fifo_full,
    output logic      [PORT_W-1:0]                 sample_data,
    output logic                                   sample_valid,
    output logic                                   sample_discard,
    output logic                                   start_trig_out,
    output logic                                   acq_running,
    output logic                                   overflow_err
);
    import acq_timing_pkg::*;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction

    acq_state_t         st_r;
    acq_state_t         st_nxt;
    logic [DATA_W-1:0]  ctrl_r;
    logic [CNT_W-1:0]   div_r;
    logic [CNT_W-1:0]   delay_r;
    logic [CNT_W-1:0]   count_r;
    logic [CNT_W-1:0]   pre_r;
    logic [CNT_W-1:0]   div_cnt_r;
    logic [CNT_W-1:0]   dly_cnt_r;
    logic [CNT_W-1:0]   taken_r;
    logic [CNT_W-1:0]   post_r;
    logic               ref_seen_r;
    logic [IN_N-1:0]    s_lvl;
    logic [IN_N-1:0]    s_rise;
    logic [IN_N-1:0]    s_fall;
    logic               tb_tick;
    logic               cont_m;
    logic               ref_m;
    logic               retrig_m;
    logic               hw_start;
    logic               ext_sclk;
    logic               hold_act;
    logic               start_edge;
    logic               ref_edge;
    logic               wr_cmd;
    logic               cmd_start;
    logic               cmd_stop;
    logic               cmd_clr;
    logic [CNT_W-1:0]   div_len;
    logic [CNT_W-1:0]   dly_len;
    logic [CNT_W-1:0]   post_len;
    logic               int_tick;
    logic               dly_end;
    logic               samp_edge;
    logic               samp_ev;
    logic               armed;
    logic               disc_ev;
    logic               ref_take;
    logic               done_ev;
    logic               start_acc;
    logic [DATA_W-1:0]  rd_nxt;

    // Every trigger and clock pin passes a synchroniser first
    acq_sync #(
        .N (IN_N)
    ) u_sync (
        .clock (clock),
        .nrst  (nrst),
        .din   ({acq_sample_clock, acq_clock_timebase, acq_hold_trig,
                 acq_stop_ref_trig, acq_start_trig}),
        .lvl   (s_lvl),
        .rise  (s_rise),
        .fall  (s_fall)
    );

    acq_timebase u_tb (
        .clock    (clock),
        .nrst     (nrst),
        .tb_sel   (ctrl_r[C_TB_LSB +: 2]),
        .tb_fall  (ctrl_r[C_TB_FALL]),
        .ext_rise (s_rise[IN_TB]),
        .ext_fall (s_fall[IN_TB]),
        .tb_tick  (tb_tick)
    );

    assign cont_m    = ctrl_r[C_CONT];
    assign ref_m     = ctrl_r[C_REF] & ~ctrl_r[C_CONT];
    assign retrig_m  = ctrl_r[C_RETRIG];
    assign hw_start  = ctrl_r[C_HWSTART];
    assign ext_sclk  = ctrl_r[C_EXT_SCLK];
    assign start_edge = ctrl_r[C_START_FALL] ? s_fall[IN_START] : s_rise[IN_START];
    assign ref_edge  = ctrl_r[C_REF_FALL] ? s_fall[IN_REF] : s_rise[IN_REF];
    assign hold_act  = ctrl_r[C_HOLD_EN] & (s_lvl[IN_HOLD] ^ ctrl_r[C_HOLD_LOW]);

    assign wr_cmd    = reg_wr & reg_hit(reg_addr, REG_CMD);
    assign cmd_start = wr_cmd & reg_wdata[CMD_START];
    assign cmd_stop  = wr_cmd & reg_wdata[CMD_STOP];
    assign cmd_clr   = wr_cmd & reg_wdata[CMD_CLR_OVF];

    // A zero length would stall the counters, so it acts as one
    assign div_len  = (div_r == 16'h0000) ? 16'h0001 : div_r;
    assign dly_len  = (delay_r == 16'h0000) ? 16'h0001 : delay_r;
    assign post_len = count_r - pre_r;

    // Divided timebase; frozen while paused
    assign int_tick = (st_r == ST_RUN) & tb_tick & ~hold_act &
                      (div_cnt_r == div_len - 16'h0001);
    assign dly_end  = (st_r == ST_DELAY) & tb_tick &
                      (dly_cnt_r == dly_len - 16'h0001);

    always_comb begin
        if (ext_sclk) begin
            samp_edge = (st_r == ST_RUN) &
                        (ctrl_r[C_SAMP_FALL] ? s_fall[IN_SCLK] : s_rise[IN_SCLK]);
        end else begin
            samp_edge = int_tick | dly_end;
        end
    end

    // Edges count only inside an acquisition and outside a pause
    assign samp_ev = samp_edge & ~hold_act &
                     ((st_r == ST_RUN) | (st_r == ST_DELAY));

    assign armed    = ref_m & (taken_r >= pre_r);
    assign disc_ev  = samp_ev & ref_m & ~ref_seen_r & (taken_r >= count_r);
    assign ref_take = (st_r == ST_RUN) & armed & ~ref_seen_r & ref_edge;

    always_comb begin
        if (cont_m) begin
            done_ev = 1'b0;
        end else if (ref_m) begin
            done_ev = (ref_seen_r & samp_ev & (post_r <= 16'h0001)) |
                      (ref_take & (post_len == 16'h0000));
        end else begin
            done_ev = samp_ev & (taken_r + 16'h0001 >= count_r);
        end
    end

    assign start_acc = ((st_r == ST_IDLE) & cmd_start & ~hw_start) |
                       ((st_r == ST_ARM) & start_edge);

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: begin
                if (cmd_start) begin
                    st_nxt = hw_start ? ST_ARM : ST_DELAY;
                end
            end
            ST_ARM: begin
                if (start_edge) begin
                    st_nxt = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (dly_end) begin
                    st_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                // Further start edges fall through unseen here
                if (done_ev) begin
                    st_nxt = (retrig_m & ~ref_m) ? ST_ARM : ST_IDLE;
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
        if (cmd_stop) begin
            st_nxt = ST_IDLE;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_r <= ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl_r  <= CTRL_RST;
            div_r   <= DIV_RST;
            delay_r <= DELAY_RST;
            count_r <= COUNT_RST;
            pre_r   <= PRE_RST;
        end else if (reg_wr) begin
            if (reg_hit(reg_addr, REG_CTRL)) begin
                ctrl_r <= reg_wdata;
            end else if (reg_hit(reg_addr, REG_DIV)) begin
                div_r <= reg_wdata[CNT_W-1:0];
            end else if (reg_hit(reg_addr, REG_DELAY)) begin
                delay_r <= reg_wdata[CNT_W-1:0];
            end else if (reg_hit(reg_addr, REG_COUNT)) begin
                count_r <= reg_wdata[CNT_W-1:0];
            end else if (reg_hit(reg_addr, REG_PRE)) begin
                pre_r <= reg_wdata[CNT_W-1:0];
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            div_cnt_r <= 16'h0000;
        end else if (st_r != ST_RUN) begin
            div_cnt_r <= 16'h0000;
        end else if (tb_tick & ~hold_act) begin
            div_cnt_r <= int_tick ? 16'h0000 : div_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            dly_cnt_r <= 16'h0000;
        end else if (st_r != ST_DELAY) begin
            dly_cnt_r <= 16'h0000;
        end else if (tb_tick) begin
            dly_cnt_r <= dly_cnt_r + 16'h0001;
        end
    end

    // Sample and reference bookkeeping, cleared per burst
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            taken_r    <= 16'h0000;
            post_r     <= 16'h0000;
            ref_seen_r <= 1'b0;
        end else if (start_acc) begin
            taken_r    <= 16'h0000;
            post_r     <= 16'h0000;
            ref_seen_r <= 1'b0;
        end else begin
            if (samp_ev & ~disc_ev & (taken_r != 16'hFFFF)) begin
                taken_r <= taken_r + 16'h0001;
            end
            if (ref_take) begin
                ref_seen_r <= 1'b1;
                post_r     <= post_len;
            end else if (ref_seen_r & samp_ev & (post_r != 16'h0000)) begin
                post_r <= post_r - 16'h0001;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sample_data    <= '0;
            sample_valid   <= 1'b0;
            sample_discard <= 1'b0;
        end else begin
            sample_valid   <= samp_ev;
            sample_discard <= disc_ev;
            if (samp_ev) begin
                sample_data <= port_in;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            start_trig_out <= 1'b0;
            acq_running    <= 1'b0;
        end else begin
            start_trig_out <= start_acc;
            acq_running    <= (st_nxt != ST_IDLE);
        end
    end

    // A discard deliberately overwrites, so it is not an overflow; set wins over clear
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            overflow_err <= 1'b0;
        end else if (samp_ev & fifo_full & ~disc_ev) begin
            overflow_err <= 1'b1;
        end else if (cmd_clr) begin
            overflow_err <= 1'b0;
        end
    end

    always_comb begin
        rd_nxt = '0;
        if (reg_hit(reg_addr, REG_CTRL)) begin
            rd_nxt = ctrl_r;
        end else if (reg_hit(reg_addr, REG_DIV)) begin
            rd_nxt[CNT_W-1:0] = div_r;
        end else if (reg_hit(reg_addr, REG_DELAY)) begin
            rd_nxt[CNT_W-1:0] = delay_r;
        end else if (reg_hit(reg_addr, REG_COUNT)) begin
            rd_nxt[CNT_W-1:0] = count_r;
        end else if (reg_hit(reg_addr, REG_PRE)) begin
            rd_nxt[CNT_W-1:0] = pre_r;
        end else if (reg_hit(reg_addr, REG_STATUS)) begin
            rd_nxt[S_RUN]     = (st_r != ST_IDLE);
            rd_nxt[S_ARMED]   = armed;
            rd_nxt[S_REFSEEN] = ref_seen_r;
            rd_nxt[S_OVF]     = overflow_err;
            rd_nxt[S_WAIT]    = (st_r == ST_ARM);
        end else if (reg_hit(reg_addr, REG_TAKEN)) begin
            rd_nxt[CNT_W-1:0] = taken_r;
        end
    end

    // Read data only in the cycle after the strobe
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_nxt : '0;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    sequence s_sw_go;
        (st_r == ST_IDLE) && cmd_start && !hw_start && !cmd_stop;
    endsequence

    sequence s_burst_end;
        (st_r == ST_RUN) && done_ev && retrig_m && !ref_m && !cmd_stop;
    endsequence

    a_no_idle_sample: assert property (
        sample_valid |-> $past(st_r) inside {ST_DELAY, ST_RUN})
        else $error("sample outside an acquisition");

    a_sw_start_go: assert property (
        s_sw_go |=> (st_r == ST_DELAY) && start_trig_out)
        else $error("software start did not begin delay");

    a_delay_length: assert property (
        (st_r == ST_DELAY) && (st_nxt == ST_RUN) |-> tb_tick && (dly_cnt_r == dly_len - 16'h0001))
        else $error("start delay length wrong");

    a_start_pulse: assert property (
        start_trig_out |=> !start_trig_out)
        else $error("start output longer than one cycle");

    a_retrig_rearm: assert property (
        s_burst_end |=> (st_r == ST_ARM) ##1 (st_r inside {ST_ARM, ST_DELAY, ST_IDLE}))
        else $error("burst end did not re-arm");

    a_start_ignored: assert property (
        (st_r == ST_RUN) && start_edge && !done_ev && !cmd_stop |=> (st_r == ST_RUN))
        else $error("start trigger disturbed a burst");

    a_hold_halts: assert property (
        (st_r == ST_RUN) && hold_act && $past(st_r) == ST_RUN |=> $stable(div_cnt_r) && !sample_valid)
        else $error("sample clock ran during pause");

    a_ref_armed: assert property (
        $rose(ref_seen_r) |-> $past(taken_r) >= $past(pre_r))
        else $error("reference taken before pretrigger samples");

    a_post_load: assert property (
        $rose(ref_seen_r) |-> post_r == count_r - pre_r)
        else $error("posttrigger count wrong");

    a_discard_full: assert property (
        sample_discard |-> sample_valid && $past(taken_r) >= $past(count_r))
        else $error("discard without full buffer");

    a_overflow_flag: assert property (
        samp_ev && fifo_full && !disc_ev |=> overflow_err)
        else $error("overflow not flagged");

endmodule // acq_timing_engine

// File: tb/trig_src.sv
// Behavioural model of the external trigger and clock sources
`timescale 1ns/1ns
module trig_src (
    output logic start_pin,
    output logic ref_pin,
    output logic hold_pin,
    output logic tb_pin,
    output logic sclk_pin
);
    // Triggers idle high so the falling edge is seen first
    initial begin
        start_pin = 1'b1;
        ref_pin   = 1'b1;
        hold_pin  = 1'b1;
        sclk_pin  = 1'b0;
    end
    // Timebase pin shares the sample clock waveform; only one is selected
    assign tb_pin = sclk_pin;
    // Moved 2 ns off the edge; held 3 cycles so the synchroniser cannot miss it
    task automatic pulse_start();
        #2;
        start_pin = 1'b0;
        #30;
        start_pin = 1'b1;
        #30;
    endtask
    task automatic pulse_ref();
        #2;
        ref_pin = 1'b0;
        #30;
        ref_pin = 1'b1;
        #30;
    endtask
    task automatic set_hold(input logic lvl);
        #2;
        hold_pin = lvl;
    endtask
    // Clock stands still low outside a frame
    task automatic sclk(input int n, input int half);
        #2;
        repeat (n) begin
            #half;
            sclk_pin = 1'b1;
            #half;
            sclk_pin = 1'b0;
        end
    endtask
endmodule // trig_src

// File: tb/di_acquisition_timing_engine_test.sv
// Self-checking bench for the acquisition timing engine
`timescale 1ns/1ns
module di_acquisition_timing_engine_test;
    import acq_timing_pkg::*;
    logic              clock, nrst, reg_wr, reg_rd, fifo_full;
    logic [ADDR_W-1:0] reg_addr;
    logic [31:0]       reg_wdata, reg_rdata, port_in, sample_data, v, k0;
    logic [31:0]       n_mismatch, samples_checked, n_samp, n_start, n_disc, cyc, t_cmd, first, last, gap;
    logic              sample_valid, sample_discard, start_trig_out, acq_running, overflow_err;
    logic              p_start, p_ref, p_hold, p_tb, p_sclk;
    integer            seed = 32'h7bb6e1da;
    int                d, c;
    acq_timing_engine dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_in(port_in), .acq_start_trig(p_start),
        .acq_stop_ref_trig(p_ref), .acq_hold_trig(p_hold), .acq_clock_timebase(p_tb),
        .acq_sample_clock(p_sclk), .fifo_full(fifo_full), .sample_data(sample_data),
        .sample_valid(sample_valid), .sample_discard(sample_discard), .start_trig_out(start_trig_out),
        .acq_running(acq_running), .overflow_err(overflow_err));
    trig_src src (.start_pin(p_start), .ref_pin(p_ref), .hold_pin(p_hold), .tb_pin(p_tb), .sclk_pin(p_sclk));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (sample_valid === 1'b1) begin
            n_samp <= n_samp + 1;
            gap    <= cyc - last;
            last   <= cyc;
            if (n_samp == 0) first <= cyc;
        end
        if (start_trig_out === 1'b1) n_start <= n_start + 1;
        if (sample_discard === 1'b1) n_disc <= n_disc + 1;
    end
    function automatic logic [31:0] exp_gap(input int dv, input int t20);
        return 32'((dv == 0 ? 1 : dv) * (t20 != 0 ? TB20_DIV : 1));
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] dt);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= dt;
        reg_wr    <= 1'b1;
        @(posedge clock);
        t_cmd = cyc;
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    // Bounded waits so a hang ends in a mismatch, not a stall
    task automatic wait_n(input logic [31:0] n);
        for (int k = 0; k < 3000 && n_samp < n; k++) @(posedge clock);
        #1;
    endtask
    task automatic wait_idle();
        @(posedge clock);
        for (int k = 0; k < 3000 && acq_running !== 1'b0; k++) @(posedge clock);
        #1;
    endtask
    task automatic go(input logic [31:0] ctrl);
        wr(REG_CTRL, ctrl);
        #1;
        n_samp  = 0;
        n_start = 0;
        n_disc  = 0;
        wr(REG_CMD, 32'h1 << CMD_START);
    endtask
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked != 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        end_sim();
    end
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, port_in, fifo_full} = '0;
        {n_mismatch, samples_checked, n_samp, n_start, n_disc, cyc, first, last, gap} = '0;
        nrst = 1'b0;
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        rd(REG_CTRL, CTRL_RST);
        rd(REG_DIV, 32'(DIV_RST));
        rd(REG_DELAY, 32'(DELAY_RST));
        rd(REG_COUNT, 32'(COUNT_RST));
        rd(REG_PRE, 32'(PRE_RST));
        rd(5'h02, 32'h0);
        go(32'h1 << C_EXT_SCLK);
        wr(REG_CMD, 32'h1 << CMD_STOP);
        src.sclk(4, 20);
        chk(n_samp, 32'h0);
        v = $random(seed);
        port_in <= v;
        wr(REG_COUNT, 32'h2);
        go(32'h0);
        wait_idle();
        chk(first - t_cmd, 32'(DELAY_RST) + 32'h1);
        chk(n_samp, 32'h2);
        chk(n_start, 32'h1);
        chk(sample_data, v);
        wr(REG_DELAY, 32'h6);
        go(32'h0);
        wait_idle();
        chk(first - t_cmd, 32'h7);
        wr(REG_DELAY, 32'h2);
        // Zero divider is a corner that must act as one
        for (int i = 0; i < 4; i++) begin
            d = {$random(seed)} % 5;
            c = 2 + {$random(seed)} % 3;
            v = $random(seed);
            port_in <= v;
            wr(REG_DIV, d);
            wr(REG_COUNT, c);
            go((i % 2) << C_TB_LSB | (i / 2) << C_TB_FALL);
            wait_idle();
            chk(n_samp, c);
            chk(gap, exp_gap(d, i % 2));
            chk(sample_data, v);
        end
        wr(REG_DIV, 32'h2);
        wr(REG_COUNT, 32'h3);
        go(32'h1 << C_HWSTART | 32'h1 << C_RETRIG | 32'h1 << C_START_FALL);
        repeat (5) @(posedge clock);
        chk(n_samp + n_start, 32'h0);
        src.pulse_start();
        src.pulse_start();
        wait_n(3);
        repeat (20) @(posedge clock);
        chk(n_samp, 32'h3);
        chk(n_start, 32'h1);
        src.pulse_start();
        wait_n(6);
        repeat (20) @(posedge clock);
        chk(n_samp, 32'h6);
        wr(REG_CMD, 32'h1 << CMD_STOP);
        wait_idle();
        chk({31'h0, acq_running}, 32'h0);
        wr(REG_DIV, 32'h8);
        wr(REG_COUNT, 32'h4);
        wr(REG_PRE, 32'h2);
        go(32'h1 << C_REF | 32'h1 << C_REF_FALL);
        src.pulse_ref();
        repeat (150) @(posedge clock);
        #1 chk({31'h0, acq_running}, 32'h1);
        rd(REG_STATUS, 32'h1 << S_RUN | 32'h1 << S_ARMED);
        chk({31'h0, n_disc != 0}, 32'h1);
        k0 = n_samp;
        wait_n(k0 + 1);
        k0 = n_samp;
        src.pulse_ref();
        src.pulse_ref();
        wait_idle();
        chk(n_samp - k0, 32'h2);
        wr(REG_PRE, 32'h0);
        wr(REG_DIV, 32'h2);
        go(32'h1 << C_CONT | 32'h1 << C_HOLD_EN | 32'h1 << C_HOLD_LOW);
        repeat (60) @(posedge clock);
        #1 chk({31'h0, acq_running}, 32'h1);
        src.set_hold(1'b0);
        repeat (5) @(posedge clock);
        #1 k0 = n_samp;
        repeat (20) @(posedge clock);
        #1 chk(n_samp - k0, 32'h0);
        src.set_hold(1'b1);
        repeat (20) @(posedge clock);
        #1 chk({31'h0, n_samp != k0}, 32'h1);
        fifo_full <= 1'b1;
        repeat (6) @(posedge clock);
        fifo_full <= 1'b0;
        #1 chk({31'h0, overflow_err}, 32'h1);
        wr(REG_CMD, 32'h1 << CMD_CLR_OVF);
        rd(REG_CMD, 32'h0);
        chk({31'h0, overflow_err}, 32'h0);
        wr(REG_CMD, 32'h1 << CMD_STOP);
        wait_idle();
        chk({31'h0, acq_running}, 32'h0);
        v = $random(seed);
        port_in <= v;
        wr(REG_COUNT, 32'h3);
        go(32'h1 << C_EXT_SCLK | 32'h1 << C_SAMP_FALL);
        repeat (10) @(posedge clock);
        src.sclk(3, 40);
        wait_idle();
        chk(n_samp, 32'h3);
        chk(sample_data, v);
        go(32'(TB_EXT) << C_TB_LSB | 32'h1 << C_TB_FALL);
        src.sclk(6, 20);
        wait_idle();
        chk(first - t_cmd, 32'hD);
        chk(n_samp, 32'h3);
        end_sim();
    end
endmodule // di_acquisition_timing_engine_test
